// ===== core/cic_pkg.sv
// Constants, register map and field layout of the two-stage comb interpolation chain.
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package cic_pkg;
  localparam int IN_W = 16;
  localparam int ACC_W = 48;
  localparam int FRAC_W = 4;
  localparam int OUT_W = 20;
  localparam int LANES = 2;
  localparam int LANE_I = 1;
  localparam int LANE_Q = 0;
  localparam int ORD_FIFTH = 5;
  localparam int ORD_SECOND = 2;
  localparam int FACT_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_LVL_W = 5;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam int DATA_W = 32;
  localparam logic [IDX_W-1:0] IDX_SCALE = 10'h006;
  localparam logic [IDX_W-1:0] IDX_SECOND_M1 = 10'h008;
  localparam logic [IDX_W-1:0] IDX_FIFTH_M1 = 10'h009;
  localparam logic [IDX_W-1:0] IDX_CTRL = 10'h020;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h021;
  localparam logic [IDX_W-1:0] IDX_OUT_COUNT = 10'h022;
  localparam logic [7:0] SCALE_MAX = 8'h19;
  localparam logic [7:0] SCALE_RST = 8'h00;
  localparam logic [FACT_W-1:0] FACT_RST = 8'h00;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam int STAT_LVL_LSB = 0;
  localparam int STAT_BUSY5_BIT = 8;
  localparam int STAT_BUSY2_BIT = 9;
  localparam int STAT_OVALID_BIT = 10;
  localparam int STAT_EN_BIT = 11;
endpackage : cic_pkg

// ===== core/cic_strm_if.sv
// Valid/ready sample stream between the chain's internal modules.
`timescale 1ns/10ps
interface cic_strm_if #(parameter int W = 32) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : cic_strm_if

// ===== core/cic_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/10ps
module cic_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  input wire logic clr,
  // Streams
  cic_strm_if.snk wr,
  cic_strm_if.src rd,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } cic_fifo_st_t;

  cic_fifo_st_t s_q;
  cic_fifo_st_t s_d;
  logic push;
  logic pop;

  assign wr.ready = (s_q.cnt != (AW+1)'(DEPTH));
  assign rd.valid = (s_q.cnt != '0);
  assign rd.data = s_q.mem[s_q.rp];
  assign level = s_q.cnt;
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = wr.data;
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || clr) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : cic_fifo

// ===== core/cic_interp_stage.sv
// One interpolating comb-integrator stage of selectable order, two lanes.
`timescale 1ns/10ps
module cic_interp_stage #(
  parameter int ORD = 5,
  parameter int IN_W = 16,
  parameter int ACC_W = 48
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  input wire logic clr,
  // Configuration
  input wire logic [cic_pkg::FACT_W-1:0] factor_m1,
  // Streams
  cic_strm_if.snk up,
  cic_strm_if.src dn,
  // State
  output logic busy
);
  localparam int L = cic_pkg::LANES;

  typedef struct packed {
    logic [L-1:0][ORD-1:0][ACC_W-1:0] dly;
    logic [L-1:0][ORD-1:0][ACC_W-1:0] acc;
    logic [L-1:0][ACC_W-1:0] smp;
    logic [L-1:0][ACC_W-1:0] dout;
    logic [cic_pkg::FACT_W-1:0] last;
    logic [cic_pkg::FACT_W-1:0] phase;
    logic have;
    logic ov;
  } cic_stage_st_t;

  cic_stage_st_t s_q;
  cic_stage_st_t s_d;
  logic [ACC_W-1:0] cb [L][ORD+1];
  logic [ACC_W-1:0] ig [L][ORD+1];
  logic step;

  // Combs at the low rate, integrators fed one sample then zeros at the high rate.
  for (genvar l = 0; l < L; l++) begin : g_lane
    assign cb[l][0] = ACC_W'($signed(up.data[l*IN_W +: IN_W]));
    assign ig[l][0] = (s_q.phase == '0) ? s_q.smp[l] : '0;
    for (genvar k = 0; k < ORD; k++) begin : g_sec
      assign cb[l][k+1] = cb[l][k] - s_q.dly[l][k];
      assign ig[l][k+1] = s_q.acc[l][k] + ig[l][k];
    end
  end

  assign up.ready = !s_q.have;
  assign dn.valid = s_q.ov;
  assign dn.data = s_q.dout;
  assign busy = s_q.have;
  assign step = s_q.have && (!s_q.ov || dn.ready);

  always_comb begin
    s_d = s_q;
    if (s_q.ov && dn.ready) begin
      s_d.ov = 1'b0;
    end
    if (up.valid && !s_q.have) begin
      for (int l = 0; l < L; l++) begin
        for (int k = 0; k < ORD; k++) begin
          s_d.dly[l][k] = cb[l][k];
        end
        s_d.smp[l] = cb[l][ORD];
      end
      s_d.have = 1'b1;
      s_d.phase = '0;
      s_d.last = factor_m1;
    end
    if (step) begin
      for (int l = 0; l < L; l++) begin
        for (int k = 0; k < ORD; k++) begin
          s_d.acc[l][k] = ig[l][k+1];
        end
        s_d.dout[l] = ig[l][ORD];
      end
      s_d.ov = 1'b1;
      s_d.phase = s_q.phase + 1'b1;
      if (s_q.phase == s_q.last) begin
        s_d.have = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || clr) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : cic_interp_stage

// ===== core/cic_interp_chain.sv
// Top of the comb interpolation chain: APB registers, input FIFO, stages and scaler.
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
module cic_interp_chain (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cic_pkg::ADDR_W-1:0] paddr,
  input wire logic [cic_pkg::DATA_W-1:0] pwdata,
  output logic [cic_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Samples from the coefficient filter
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [cic_pkg::IN_W-1:0] in_i,
  input wire logic [cic_pkg::IN_W-1:0] in_q,
  // Samples to the tuner
  output logic out_valid,
  input wire logic out_ready,
  output logic [cic_pkg::OUT_W-1:0] out_i,
  output logic [cic_pkg::OUT_W-1:0] out_q
);
  localparam int L = cic_pkg::LANES;
  localparam int ACC_W = cic_pkg::ACC_W;
  localparam int EXT_W = cic_pkg::ACC_W + cic_pkg::FRAC_W;

  typedef struct packed {
    logic [7:0] scale;
    logic [cic_pkg::FACT_W-1:0] second_m1;
    logic [cic_pkg::FACT_W-1:0] fifth_m1;
    logic en;
    logic clr;
    logic [cic_pkg::DATA_W-1:0] rdata;
    logic slverr;
    logic [L-1:0][cic_pkg::OUT_W-1:0] odata;
    logic ov;
    logic [cic_pkg::DATA_W-1:0] ocnt;
  } cic_top_st_t;

  cic_top_st_t s_q;
  cic_top_st_t s_d;

  //----------------------------------------------------------------------------
  // Sample path
  //----------------------------------------------------------------------------
  cic_strm_if #(.W(L*cic_pkg::IN_W)) fin ();
  cic_strm_if #(.W(L*cic_pkg::IN_W)) fout ();
  cic_strm_if #(.W(L*cic_pkg::IN_W)) s5in ();
  cic_strm_if #(.W(L*ACC_W)) s5out ();
  cic_strm_if #(.W(L*ACC_W)) s2out ();

  logic [cic_pkg::FIFO_LVL_W-1:0] fifo_lvl;
  logic busy5;
  logic busy2;

  assign fin.valid = in_valid;
  assign fin.data = {in_i, in_q};
  assign in_ready = fin.ready;

  cic_fifo #(.W(L*cic_pkg::IN_W), .DEPTH(cic_pkg::FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .srst(srst),
    .clr(s_q.clr),
    .wr(fin),
    .rd(fout),
    .level(fifo_lvl)
  );

  // A disabled chain holds samples in the FIFO, which then back-pressures the source.
  assign s5in.valid = fout.valid && s_q.en;
  assign s5in.data = fout.data;
  assign fout.ready = s5in.ready && s_q.en;

  cic_interp_stage #(
    .ORD(cic_pkg::ORD_FIFTH),
    .IN_W(cic_pkg::IN_W),
    .ACC_W(ACC_W)
  ) u_fifth_order_stage (
    .mclk(mclk),
    .srst(srst),
    .clr(s_q.clr),
    .factor_m1(s_q.fifth_m1),
    .up(s5in),
    .dn(s5out),
    .busy(busy5)
  );

  cic_interp_stage #(
    .ORD(cic_pkg::ORD_SECOND),
    .IN_W(ACC_W),
    .ACC_W(ACC_W)
  ) u_second_order_stage (
    .mclk(mclk),
    .srst(srst),
    .clr(s_q.clr),
    .factor_m1(s_q.second_m1),
    .up(s5out),
    .dn(s2out),
    .busy(busy2)
  );

  //----------------------------------------------------------------------------
  // Per-lane scalers with one shared scale setting
  //----------------------------------------------------------------------------
  // Fraction bits are appended before the shift so that the right shift drops
  // no resolution within the output word.
  logic [cic_pkg::OUT_W-1:0] scaled [L];
  for (genvar l = 0; l < L; l++) begin : g_scale
    logic signed [EXT_W-1:0] ext;
    logic signed [EXT_W-1:0] shr;
    assign ext = {s2out.data[l*ACC_W +: ACC_W], {cic_pkg::FRAC_W{1'b0}}};
    assign shr = ext >>> s_q.scale;
    assign scaled[l] = shr[cic_pkg::OUT_W-1:0];
  end

  assign s2out.ready = !s_q.ov || out_ready;
  assign out_valid = s_q.ov;
  assign out_i = s_q.odata[cic_pkg::LANE_I];
  assign out_q = s_q.odata[cic_pkg::LANE_Q];

  //----------------------------------------------------------------------------
  // APB register file
  //----------------------------------------------------------------------------
  logic [cic_pkg::IDX_W-1:0] idx;
  logic aligned;
  logic setup;
  logic wr_acc;
  logic hit;
  logic [cic_pkg::DATA_W-1:0] rd_word;
  logic [cic_pkg::DATA_W-1:0] status;

  assign idx = paddr[cic_pkg::ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite && aligned;
  assign pready = 1'b1;
  assign prdata = s_q.rdata;
  assign pslverr = s_q.slverr;

  always_comb begin
    status = '0;
    status[cic_pkg::STAT_LVL_LSB +: cic_pkg::FIFO_LVL_W] = fifo_lvl;
    status[cic_pkg::STAT_BUSY5_BIT] = busy5;
    status[cic_pkg::STAT_BUSY2_BIT] = busy2;
    status[cic_pkg::STAT_OVALID_BIT] = s_q.ov;
    status[cic_pkg::STAT_EN_BIT] = s_q.en;
  end

  always_comb begin
    rd_word = '0;
    hit = aligned;
    case (idx)
      cic_pkg::IDX_SCALE: begin
        rd_word[7:0] = s_q.scale;
      end
      cic_pkg::IDX_SECOND_M1: begin
        rd_word[cic_pkg::FACT_W-1:0] = s_q.second_m1;
      end
      cic_pkg::IDX_FIFTH_M1: begin
        rd_word[cic_pkg::FACT_W-1:0] = s_q.fifth_m1;
      end
      cic_pkg::IDX_CTRL: begin
        rd_word[cic_pkg::CTRL_EN_BIT] = s_q.en;
      end
      cic_pkg::IDX_STATUS: begin
        rd_word = status;
      end
      cic_pkg::IDX_OUT_COUNT: begin
        rd_word = s_q.ocnt;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  //----------------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.clr = 1'b0;
    if (setup) begin
      s_d.rdata = (pwrite || !hit) ? '0 : rd_word;
      s_d.slverr = !hit;
    end
    if (wr_acc) begin
      case (idx)
        cic_pkg::IDX_SCALE: begin
          if (pwdata[7:0] > cic_pkg::SCALE_MAX) begin
            s_d.scale = cic_pkg::SCALE_MAX;
          end else begin
            s_d.scale = pwdata[7:0];
          end
        end
        cic_pkg::IDX_SECOND_M1: begin
          s_d.second_m1 = pwdata[cic_pkg::FACT_W-1:0];
        end
        cic_pkg::IDX_FIFTH_M1: begin
          s_d.fifth_m1 = pwdata[cic_pkg::FACT_W-1:0];
        end
        cic_pkg::IDX_CTRL: begin
          s_d.en = pwdata[cic_pkg::CTRL_EN_BIT];
          s_d.clr = pwdata[cic_pkg::CTRL_CLR_BIT];
        end
        default: begin
          s_d.clr = 1'b0;
        end
      endcase
    end
    if (s_q.ov && out_ready) begin
      s_d.ov = 1'b0;
      s_d.ocnt = s_q.ocnt + 1'b1;
    end
    if (s2out.valid && s2out.ready) begin
      for (int l = 0; l < L; l++) begin
        s_d.odata[l] = scaled[l];
      end
      s_d.ov = 1'b1;
    end
    if (s_q.clr) begin
      s_d.ov = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_q <= '0;
      s_q.scale <= cic_pkg::SCALE_RST;
      s_q.second_m1 <= cic_pkg::FACT_RST;
      s_q.fifth_m1 <= cic_pkg::FACT_RST;
      s_q.en <= cic_pkg::CTRL_EN_RST;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : cic_interp_chain

// ===== verif/cic_interp_chain_chk.sv
// Port checker of the comb interpolation chain.
`timescale 1ns/10ps
module cic_interp_chain_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cic_pkg::ADDR_W-1:0] paddr,
  input wire logic [cic_pkg::DATA_W-1:0] pwdata,
  input wire logic [cic_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Streams
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [cic_pkg::OUT_W-1:0] out_i,
  input wire logic [cic_pkg::OUT_W-1:0] out_q
);
  logic rst_q;
  logic [9:0] ix;
  logic stp;
  logic map;
  logic clr_q;
  // A clear write drops a held output one cycle later, so the hold check skips that cycle.
  always_ff @(posedge mclk) begin
    rst_q <= srst;
    clr_q <= psel && penable && pwrite && paddr == {cic_pkg::IDX_CTRL, 2'h0}
      && pwdata[cic_pkg::CTRL_CLR_BIT];
  end
  assign ix = paddr[11:2];
  assign stp = psel && !penable;
  assign map = paddr[1:0] == 2'h0 && (ix inside {cic_pkg::IDX_SCALE, cic_pkg::IDX_SECOND_M1,
    cic_pkg::IDX_FIFTH_M1, cic_pkg::IDX_CTRL, cic_pkg::IDX_STATUS, cic_pkg::IDX_OUT_COUNT});
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  chk_pready_high: assert property (pready) else $error("pready low");
  chk_out_hold: assert property (out_valid && !out_ready && !clr_q |=> out_valid
    && $stable(out_i) && $stable(out_q)) else $error("output not held");
  chk_reset_clear: assert property (rst_q |-> !out_valid && out_i == '0 && out_q == '0
    && in_ready) else $error("state not cleared");
  chk_map_err: assert property (stp && !map |=> pslverr && prdata == '0)
    else $error("unmapped access accepted");
  chk_map_ok: assert property (stp && map |=> !pslverr) else $error("mapped access refused");
  chk_scale_max: assert property (stp && !pwrite && ix == cic_pkg::IDX_SCALE |=>
    prdata <= 32'h19) else $error("scale above limit");
  chk_fact_width: assert property (stp && !pwrite && ix[9:1] == 9'h004 |=>
    prdata[31:8] == '0) else $error("factor too wide");
  chk_status_bits: assert property (stp && !pwrite && ix == cic_pkg::IDX_STATUS |=>
    prdata[10] == $past(out_valid) && prdata[4:0] <= 5'h10) else $error("status wrong");
  cover property (in_valid && !in_ready);
  cover property (out_valid && !out_ready);
  cover property (stp && !map);
endmodule : cic_interp_chain_chk
bind cic_interp_chain cic_interp_chain_chk u_chk (.mclk(mclk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid),
  .out_ready(out_ready), .out_i(out_i), .out_q(out_q));

// ===== verif/cic_tuner_model.sv
// Downstream tuner model that takes output samples with optional stalls.
`timescale 1ns/10ps
module cic_tuner_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Stream from the chain
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [cic_pkg::OUT_W-1:0] out_i,
  input wire logic [cic_pkg::OUT_W-1:0] out_q,
  // Control and capture
  input wire logic stall,
  output logic got,
  output logic [cic_pkg::OUT_W-1:0] got_i,
  output logic [cic_pkg::OUT_W-1:0] got_q
);
  logic [7:0] lfsr_q = 8'h5A;
  assign out_ready = !stall || lfsr_q[0];
  always @(posedge mclk) begin
    lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    got <= out_valid && out_ready && !srst;
    got_i <= out_i;
    got_q <= out_q;
  end
endmodule : cic_tuner_model

// ===== verif/tb.sv
// Self-checking bench of the comb interpolation chain.
`timescale 1ns/10ps
module tb;
  logic mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, st = 73;
  logic pready, pslverr, err, in_valid = 0, in_ready, out_valid, out_ready, stall = 1, got;
  logic [15:0] in_i = '0, in_q = '0, x, y;
  logic [19:0] out_i, out_q, got_i, got_q;
  logic [39:0] exq[$];
  logic exact = 0;
  int fail_count = 0, checked = 0, n_rx = 0, c0;
  logic [9:0] ixs [6] = '{cic_pkg::IDX_SCALE, cic_pkg::IDX_SECOND_M1, cic_pkg::IDX_FIFTH_M1,
    cic_pkg::IDX_CTRL, cic_pkg::IDX_STATUS, cic_pkg::IDX_OUT_COUNT};
  logic [31:0] rsv [6] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h800, 32'h0};
  always #25 mclk = ~mclk;
  cic_interp_chain dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_i(in_i), .in_q(in_q),
    .out_valid(out_valid), .out_ready(out_ready), .out_i(out_i), .out_q(out_q));
  cic_tuner_model u_sink (.mclk(mclk), .srst(srst), .out_valid(out_valid),
    .out_ready(out_ready), .out_i(out_i), .out_q(out_q), .stall(stall), .got(got),
    .got_i(got_i), .got_q(got_q));
  function automatic logic [31:0] rnd();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction : rnd
  function automatic logic [19:0] ex(input logic [15:0] v, input int g, input int s);
    int r;
    r = ($signed(v) * g * 16) >>> s;
    return r[19:0];
  endfunction : ex
  task automatic cmp(input logic [39:0] gv, input logic [39:0] ev);
    checked++;
    if (gv !== ev) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, gv, ev);
    end
  endtask : cmp
  task automatic final_report();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic apb(input logic w, input logic [9:0] ix, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {ix, 2'h0};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge mclk);
  endtask : apb
  task automatic send(input int n, input logic fix, input int g, input int s);
    for (int k = 0; k < n; k++) begin
      if (!fix) begin
        x = 16'(rnd());
        y = 16'(rnd());
      end
      in_valid <= 1;
      in_i <= x;
      in_q <= y;
      exq.push_back({ex(x, g, s), ex(y, g, s)});
      do @(posedge mclk); while (in_ready !== 1'b1);
    end
    in_valid <= 0;
    in_i <= ~x;
    in_q <= ~y;
  endtask : send
  task automatic drain(input int n);
    repeat (3000) if (n_rx < n) @(posedge mclk);
    cmp(n_rx, n);
  endtask : drain
  always @(posedge mclk) begin
    if (got === 1'b1) begin
      n_rx++;
      if (exact) cmp({got_i, got_q}, exq.pop_front());
    end
  end
  initial begin
    #1000000;
    fail_count++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge mclk);
    srst <= 0;
    @(posedge mclk);
    for (int k = 0; k < 6; k++) begin
      apb(0, ixs[k], 0);
      cmp(rd, rsv[k]);
    end
    apb(0, 10'h007, 0);
    cmp({err, rd}, 40'h1_0000_0000);
    // ----------------------------------------
    // Fill the buffer with draining held off.
    // ----------------------------------------
    apb(1, cic_pkg::IDX_CTRL, 0);
    send(16, 0, 1, 0);
    @(posedge mclk);
    cmp(in_ready, 0);
    apb(0, cic_pkg::IDX_STATUS, 0);
    cmp(rd, 32'h10);
    exact = 1;
    apb(1, cic_pkg::IDX_CTRL, 1);
    drain(16);
    // ----------------------------------------
    // Interpolate a constant by two and three.
    // ----------------------------------------
    exact = 0;
    // A factor change leaves integrator residue behind, so the chain starts clean.
    apb(1, cic_pkg::IDX_CTRL, 3);
    apb(1, cic_pkg::IDX_SCALE, 30);
    apb(0, cic_pkg::IDX_SCALE, 0);
    cmp(rd, 32'h19);
    apb(1, cic_pkg::IDX_SCALE, 6);
    apb(1, cic_pkg::IDX_FIFTH_M1, 1);
    apb(1, cic_pkg::IDX_SECOND_M1, 2);
    apb(0, cic_pkg::IDX_SECOND_M1, 0);
    cmp(rd, 32'h2);
    apb(0, cic_pkg::IDX_OUT_COUNT, 0);
    c0 = rd;
    n_rx = 0;
    x = 16'(rnd());
    y = 16'(rnd());
    send(12, 1, 48, 6);
    drain(72);
    cmp({got_i, got_q}, exq[$]);
    apb(0, cic_pkg::IDX_OUT_COUNT, 0);
    cmp(rd - c0, 72);
    // ----------------------------------------
    // Clear in mid-stream, then unity gain.
    // ----------------------------------------
    send(3, 0, 1, 0);
    apb(1, cic_pkg::IDX_CTRL, 3);
    @(posedge mclk);
    cmp(out_valid, 0);
    apb(1, cic_pkg::IDX_FIFTH_M1, 0);
    apb(1, cic_pkg::IDX_SECOND_M1, 0);
    apb(1, cic_pkg::IDX_SCALE, 0);
    exq.delete();
    n_rx = 0;
    exact = 1;
    send(6, 0, 1, 0);
    drain(6);
    final_report();
  end
endmodule : tb
